// File: hw/usrtbp_map.vh
`ifndef USRTBP_MAP_VH
`define USRTBP_MAP_VH

// Sixteen data aliases, one aligned word each
`define USRTBP_WIN_BASE 32'h50001130
`define USRTBP_WIN_LAST 32'h5000116C
`define USRTBP_WIN2_ADDR 32'h50001138
`define USRTBP_WIN3_ADDR 32'h5000113C
`define USRTBP_CTRL_ADDR 32'h50001100
`define USRTBP_STAT_ADDR 32'h50001104

`define USRTBP_CTRL_FEN 0
`define USRTBP_CTRL_IR 1
`define USRTBP_STAT_READY 0
`define USRTBP_STAT_OE 1
`define USRTBP_STAT_EMPTY 5
`define USRTBP_STAT_TFULL 6

`define USRTBP_DATA_W 8
`define USRTBP_FIFO_DEPTH 16
`define USRTBP_FIFO_AW 4
`define USRTBP_FIFO_CW 5
`define USRTBP_RST_BYTE 8'h00
`define USRTBP_RST_WORD 32'h00000000

// Line timing: rate in Hz, then derived cycles per oversample tick
`define USRTBP_CLK_HZ 50000000
`define USRTBP_BAUD 115200
`define USRTBP_OVS 16
`define USRTBP_TICK_DIV (`USRTBP_CLK_HZ / (`USRTBP_BAUD * `USRTBP_OVS))
`define USRTBP_SUB_LAST 4'hF
`define USRTBP_SUB_MID 4'h7
`define USRTBP_IR_PULSE 4'h3
`define USRTBP_IR_HOLD 5'h10
`define USRTBP_BIT_LAST 3'h7

`endif

// File: hw/usrtbp_fifo.v
`timescale 1ns/1ps
`default_nettype none
module usrtbp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4,
	parameter CW = 5
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data_q
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_q;
	reg [AW-1:0] rptr_q;
	reg [CW-1:0] cnt_q;
	wire push;
	wire pop;
	wire [AW-1:0] rptr_d;
	wire [CW-1:0] left;
	localparam integer DEPTH_I = DEPTH;
	localparam [CW-1:0] FULL_CNT = DEPTH_I[CW-1:0];
	localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

	assign in_ready = (cnt_q != FULL_CNT);
	assign out_valid = (cnt_q != {CW{1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign rptr_d = pop ? rptr_q + 1'b1 : rptr_q;
	assign left = pop ? cnt_q - ONE : cnt_q;

	always @(posedge ref_clk) begin
		if (push)
			mem[wptr_q] <= in_data;
	end

	// Head word is kept in a register so reads never see the array directly
	always @(posedge ref_clk) begin
		if (sys_rst || flush) begin
			wptr_q <= {AW{1'b0}};
			rptr_q <= {AW{1'b0}};
			cnt_q <= {CW{1'b0}};
			out_data_q <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			rptr_q <= rptr_d;
			cnt_q <= left + (push ? ONE : {CW{1'b0}});
			if (left == {CW{1'b0}}) begin
				if (push)
					out_data_q <= in_data;
			end else begin
				out_data_q <= mem[rptr_d];
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/usrtbp_port.v
// Contract
// R1: Sixteen word locations all alias receive buffer on read, holding register on write.
// R2: Low byte reads the character from serial line, or infrared line in infrared mode.
// R3: Software trusts received byte only while data ready flag is set.
// R4: FIFOs off: new character overwrites unread buffer and flags overrun.
// R5: FIFOs on: reading an alias returns the oldest receive FIFO entry.
// R6: Receive FIFO full: incoming character dropped, contents kept, overrun flagged.
// R7: Written byte goes out serial line, or active-low infrared line in infrared mode.
// R8: Software writes only while holding empty flag (bit 5 of status) is set.
// R9: FIFOs off: one write clears the holding empty flag.
// R10: FIFOs off: further writes before flag sets again replace pending character.
// R11: FIFOs on: writes accepted until transmit FIFO of 16 entries is full.
// R12: Write into full transmit FIFO is dropped, contents unchanged.
// R13: Upper reserved byte reads zero; writes there do nothing.
`timescale 1ns/1ps
`default_nettype none
`include "usrtbp_map.vh"
module usrtbp_port (
	input wire ref_clk,
	input wire sys_rst,
	input wire [31:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [31:0] bus_rdata_q,
	input wire ser_in,
	input wire ir_in,
	output reg ser_out_q,
	output reg ir_out_n_q,
	output reg data_ready_q,
	output reg holding_empty_q,
	output reg overrun_q,
	output reg fifo_enable_q,
	output reg ir_mode_q
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_START = 2'h1;
	localparam [1:0] ST_DATA = 2'h2;
	localparam [1:0] ST_STOP = 2'h3;
	localparam integer DIV_COUNT = `USRTBP_TICK_DIV - 1;
	localparam [7:0] DIV_LAST = DIV_COUNT[7:0];

	function in_window;
		input [31:0] a;
		begin
			in_window = (a >= `USRTBP_WIN_BASE) && (a <= `USRTBP_WIN_LAST) && (a[1:0] == 2'h0);
		end
	endfunction

	reg [7:0] div_q;
	reg [4:0] irs_q;
	reg [1:0] rx_st_q;
	reg [3:0] rx_sub_q;
	reg [2:0] rx_cnt_q;
	reg [7:0] rx_sh_q;
	reg rx_done_q;
	reg [7:0] receive_buffer_q;
	reg ready_flag_q;
	reg [1:0] tx_st_q;
	reg [3:0] tx_sub_q;
	reg [2:0] tx_cnt_q;
	reg [7:0] tx_sh_q;
	reg [7:0] transmit_holding_q;
	reg holding_full_q;
	reg tx_bit;

	wire tick = (div_q == DIV_LAST);
	wire win_rd = bus_rd & in_window(bus_addr); // R1
	wire win_wr = bus_wr & in_window(bus_addr); // R1
	wire ctrl_wr = bus_wr & (bus_addr == `USRTBP_CTRL_ADDR);
	wire stat_rd = bus_rd & (bus_addr == `USRTBP_STAT_ADDR);
	// Changing the FIFO mode empties both FIFOs so no stale bytes cross modes
	wire flush = ctrl_wr & (bus_wdata[`USRTBP_CTRL_FEN] != fifo_enable_q);
	wire rx_line = ir_mode_q ? (ir_in & (irs_q == 5'h00)) : ser_in; // R2

	wire rxf_ready;
	wire rxf_valid;
	wire [7:0] rxf_data;
	wire txf_ready;
	wire txf_valid;
	wire [7:0] txf_data;
	wire tx_avail = fifo_enable_q ? txf_valid : holding_full_q;
	wire [7:0] tx_src = fifo_enable_q ? txf_data : transmit_holding_q;
	wire tx_load = tick & (tx_st_q == ST_IDLE) & tx_avail;
	wire ready_now = fifo_enable_q ? rxf_valid : ready_flag_q;
	wire empty_now = fifo_enable_q ? ~txf_valid : ~holding_full_q;

	usrtbp_fifo #(
		.WIDTH(`USRTBP_DATA_W),
		.DEPTH(`USRTBP_FIFO_DEPTH),
		.AW(`USRTBP_FIFO_AW),
		.CW(`USRTBP_FIFO_CW)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.flush(flush),
		.in_valid(rx_done_q & fifo_enable_q),
		.in_ready(rxf_ready),
		.in_data(rx_sh_q),
		.out_valid(rxf_valid),
		.out_ready(win_rd & fifo_enable_q),
		.out_data_q(rxf_data)
	); // R5 R6

	usrtbp_fifo #(
		.WIDTH(`USRTBP_DATA_W),
		.DEPTH(`USRTBP_FIFO_DEPTH),
		.AW(`USRTBP_FIFO_AW),
		.CW(`USRTBP_FIFO_CW)
	) u_tx_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.flush(flush),
		.in_valid(win_wr & fifo_enable_q),
		.in_ready(txf_ready),
		.in_data(bus_wdata[7:0]),
		.out_valid(txf_valid),
		.out_ready(tx_load & fifo_enable_q),
		.out_data_q(txf_data)
	); // R11 R12

	always @(posedge ref_clk) begin
		if (sys_rst)
			div_q <= 8'h00;
		else if (tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// Infrared pulses are short; stretch each by one bit time past its end to get NRZ data
	always @(posedge ref_clk) begin
		if (sys_rst)
			irs_q <= 5'h00;
		else if (!ir_in)
			irs_q <= `USRTBP_IR_HOLD;
		else if (tick && irs_q != 5'h00)
			irs_q <= irs_q - 5'h01;
	end

	// Receiver: 8N1, data sampled mid-bit; framing errors are not checked
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_st_q <= ST_IDLE;
			rx_sub_q <= 4'h0;
			rx_cnt_q <= 3'h0;
			rx_sh_q <= `USRTBP_RST_BYTE;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			if (tick) begin
				case (rx_st_q)
				ST_IDLE: begin
					rx_sub_q <= 4'h0;
					if (!rx_line)
						rx_st_q <= ST_START;
				end
				ST_START: begin
					if (rx_sub_q == `USRTBP_SUB_MID) begin
						rx_sub_q <= 4'h0;
						rx_cnt_q <= 3'h0;
						rx_st_q <= rx_line ? ST_IDLE : ST_DATA;
					end else begin
						rx_sub_q <= rx_sub_q + 4'h1;
					end
				end
				ST_DATA: begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rx_sub_q == `USRTBP_SUB_LAST) begin
						rx_sh_q <= {rx_line, rx_sh_q[7:1]};
						rx_cnt_q <= rx_cnt_q + 3'h1;
						if (rx_cnt_q == `USRTBP_BIT_LAST)
							rx_st_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rx_sub_q == `USRTBP_SUB_LAST) begin
						rx_done_q <= 1'b1;
						rx_st_q <= ST_IDLE;
					end
				end
				default: rx_st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Single-entry receive buffer; an arriving byte beats a same-cycle read
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			receive_buffer_q <= `USRTBP_RST_BYTE;
			ready_flag_q <= 1'b0;
		end else if (rx_done_q && !fifo_enable_q) begin
			receive_buffer_q <= rx_sh_q; // R4
			ready_flag_q <= 1'b1;
		end else if (win_rd || flush) begin
			ready_flag_q <= 1'b0;
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst)
			overrun_q <= 1'b0;
		else if (rx_done_q && (fifo_enable_q ? !rxf_ready : ready_flag_q))
			overrun_q <= 1'b1; // R4 R6
		else if (stat_rd)
			overrun_q <= 1'b0;
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			fifo_enable_q <= 1'b0;
			ir_mode_q <= 1'b0;
		end else if (ctrl_wr) begin
			fifo_enable_q <= bus_wdata[`USRTBP_CTRL_FEN];
			ir_mode_q <= bus_wdata[`USRTBP_CTRL_IR];
		end
	end

	// Holding register: a write while full simply replaces the pending byte
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			transmit_holding_q <= `USRTBP_RST_BYTE;
			holding_full_q <= 1'b0;
		end else if (win_wr && !fifo_enable_q) begin
			transmit_holding_q <= bus_wdata[7:0]; // R10 R13
			holding_full_q <= 1'b1; // R9
		end else if ((tx_load && !fifo_enable_q) || flush) begin
			holding_full_q <= 1'b0;
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_st_q <= ST_IDLE;
			tx_sub_q <= 4'h0;
			tx_cnt_q <= 3'h0;
			tx_sh_q <= `USRTBP_RST_BYTE;
		end else if (tick) begin
			tx_sub_q <= tx_sub_q + 4'h1;
			case (tx_st_q)
			ST_IDLE: begin
				tx_sub_q <= 4'h0;
				if (tx_avail) begin
					tx_sh_q <= tx_src;
					tx_st_q <= ST_START;
				end
			end
			ST_START: begin
				tx_cnt_q <= 3'h0;
				if (tx_sub_q == `USRTBP_SUB_LAST)
					tx_st_q <= ST_DATA;
			end
			ST_DATA: begin
				if (tx_sub_q == `USRTBP_SUB_LAST) begin
					tx_sh_q <= {1'b1, tx_sh_q[7:1]};
					tx_cnt_q <= tx_cnt_q + 3'h1;
					if (tx_cnt_q == `USRTBP_BIT_LAST)
						tx_st_q <= ST_STOP;
				end
			end
			ST_STOP: begin
				if (tx_sub_q == `USRTBP_SUB_LAST)
					tx_st_q <= ST_IDLE;
			end
			default: tx_st_q <= ST_IDLE;
			endcase
		end
	end

	always @* begin
		case (tx_st_q)
		ST_START: tx_bit = 1'b0;
		ST_DATA: tx_bit = tx_sh_q[0];
		default: tx_bit = 1'b1;
		endcase
	end

	// Infrared sends a low pulse of 3/16 bit for each zero bit
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			ser_out_q <= 1'b1;
			ir_out_n_q <= 1'b1;
		end else begin
			ser_out_q <= ir_mode_q | tx_bit; // R7
			ir_out_n_q <= ~(ir_mode_q & ~tx_bit & (tx_sub_q < `USRTBP_IR_PULSE)); // R7
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			data_ready_q <= 1'b0;
			holding_empty_q <= 1'b1;
		end else begin
			data_ready_q <= ready_now; // R3
			holding_empty_q <= empty_now; // R8
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_rdata_q <= `USRTBP_RST_WORD;
		end else begin
			bus_rdata_q <= `USRTBP_RST_WORD;
			if (win_rd)
				bus_rdata_q[7:0] <= fifo_enable_q ? rxf_data : receive_buffer_q; // R2 R5 R13
			else if (bus_rd && bus_addr == `USRTBP_CTRL_ADDR) begin
				bus_rdata_q[`USRTBP_CTRL_FEN] <= fifo_enable_q;
				bus_rdata_q[`USRTBP_CTRL_IR] <= ir_mode_q;
			end else if (stat_rd) begin
				bus_rdata_q[`USRTBP_STAT_READY] <= ready_now;
				bus_rdata_q[`USRTBP_STAT_OE] <= overrun_q;
				bus_rdata_q[`USRTBP_STAT_EMPTY] <= empty_now;
				bus_rdata_q[`USRTBP_STAT_TFULL] <= fifo_enable_q & ~txf_ready;
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/usrtbp_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "usrtbp_map.vh"
module usrtbp_port_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata_q,
	input wire logic ser_in,
	input wire logic ir_in,
	input wire logic ser_out_q,
	input wire logic ir_out_n_q,
	input wire logic data_ready_q,
	input wire logic holding_empty_q,
	input wire logic overrun_q,
	input wire logic fifo_enable_q,
	input wire logic ir_mode_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire alias_hit = bus_addr >= `USRTBP_WIN_BASE && bus_addr <= `USRTBP_WIN_LAST
		&& bus_addr[1:0] == 2'h0;
	wire stat_rd = bus_rd && bus_addr == `USRTBP_STAT_ADDR;
	read_idle_a: assert property (!$past(bus_rd) |-> bus_rdata_q == 32'h0)
		else $error("read data outside answer cycle");
	upper_zero_a: assert property (bus_rdata_q[31:8] == 24'h0)
		else $error("reserved byte not zero");
	empty_clear_a: assert property (bus_wr && alias_hit && !fifo_enable_q |-> ##2 !holding_empty_q)
		else $error("holding empty kept after write");
	ready_clear_a: assert property (bus_rd && alias_hit && !fifo_enable_q && data_ready_q |-> ##2 !data_ready_q)
		else $error("data ready kept after read");
	ctrl_load_a: assert property (bus_wr && bus_addr == `USRTBP_CTRL_ADDR |=> {ir_mode_q, fifo_enable_q} == $past(bus_wdata[1:0]))
		else $error("control bits not loaded");
	ir_idle_a: assert property (!ir_mode_q && !$past(ir_mode_q) |-> ir_out_n_q)
		else $error("infrared out active in normal mode");
	ser_hold_a: assert property (ir_mode_q && $past(ir_mode_q) |-> ser_out_q)
		else $error("serial out active in infrared mode");
	ovr_keep_a: assert property ($fell(overrun_q) |-> $past(stat_rd) || $past(stat_rd, 2))
		else $error("overrun lost without status read");
endmodule
bind usrtbp_port usrtbp_port_checker usrtbp_port_checker_i (.ref_clk, .sys_rst, .bus_addr,
	.bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q, .ser_in, .ir_in, .ser_out_q, .ir_out_n_q,
	.data_ready_q, .holding_empty_q, .overrun_q, .fifo_enable_q, .ir_mode_q);
`default_nettype wire

// File: verif/usrtbp_line.sv
`timescale 1ns/1ps
`default_nettype none
module usrtbp_line (
	input wire logic ref_clk,
	input wire logic tx_line,
	output logic rx_line
);
	localparam int BIT = 432;
	logic [7:0] got[$];
	initial rx_line = 1'b1;
	// 8N1, LSB first; line rests high after the stop bit
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (BIT) @(posedge ref_clk);
		end
	endtask
	// Samples mid-bit; stop bit not judged
	initial begin
		logic [7:0] s;
		forever begin
			@(negedge tx_line);
			repeat (BIT / 2) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge ref_clk);
				s[i] = tx_line;
			end
			got.push_back(s);
			repeat (BIT) @(posedge ref_clk);
		end
	end
endmodule
`default_nettype wire

// File: verif/usrtbp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "usrtbp_map.vh"
module usrtbp_port_test;
	logic ref_clk, sys_rst, bus_wr, bus_rd, ser_in, ser_out_q, ir_out_n_q;
	logic data_ready_q, holding_empty_q, overrun_q, fifo_enable_q, ir_mode_q;
	logic [31:0] bus_addr, bus_wdata, bus_rdata_q, rnd, v;
	logic [7:0] b[4];
	int err_count = 0;
	int comparisons = 0;
	usrtbp_port usrtbp_port_i (.ref_clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
		.bus_rdata_q, .ser_in, .ir_in(ir_out_n_q), .ser_out_q, .ir_out_n_q, .data_ready_q,
		.holding_empty_q, .overrun_q, .fifo_enable_q, .ir_mode_q);
	usrtbp_line usrtbp_line_i (.ref_clk, .tx_line(ser_out_q), .rx_line(ser_in));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] alias_at(input logic [31:0] s);
		return `USRTBP_WIN_BASE + {26'h0, s[3:0], 2'h0};
	endfunction
	function automatic logic [31:0] stat(input logic rdy, oe, emp, full);
		return {25'h0, full, emp, 3'h0, oe, rdy};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// A gap cycle after each strobe keeps one assignment per signal per step
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		@(posedge ref_clk);
		d = bus_rdata_q;
	endtask
	// Kind 0: data ready, 1: n bytes seen on the line, 2: holding empty
	task automatic hold_until(input int kind, input int n);
		int t;
		for (t = 0; t < 20000; t++) begin
			@(posedge ref_clk);
			if (kind == 0 && data_ready_q === 1'b1) break;
			if (kind == 1 && usrtbp_line_i.got.size() >= n) break;
			if (kind == 2 && holding_empty_q === 1'b1) break;
		end
		if (t == 20000) begin
			err_count++;
			wrap_up();
		end
	endtask
	initial begin
		{bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
		rnd = 32'hFF5A;
		sys_rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(`USRTBP_STAT_ADDR, v);
		check(v, stat(0, 0, 1, 0));
		rd(32'h50001200, v);
		check(v, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			b[i] = rnd[7:0];
		end
		usrtbp_line_i.send(b[0]);
		usrtbp_line_i.send(b[1]);
		hold_until(0, 0);
		rd(alias_at(rnd), v);
		check(v, {24'h0, b[1]});
		rd(`USRTBP_STAT_ADDR, v);
		check(v, stat(0, 1, 1, 0));
		rd(`USRTBP_STAT_ADDR, v);
		check(v, stat(0, 0, 1, 0));
		wr(`USRTBP_CTRL_ADDR, 32'h1);
		usrtbp_line_i.send(b[2]);
		usrtbp_line_i.send(b[3]);
		hold_until(0, 0);
		rd(alias_at(rnd), v);
		check(v, {24'h0, b[2]});
		rnd = lfsr(rnd);
		rd(alias_at(rnd), v);
		check(v, {24'h0, b[3]});
		wr(`USRTBP_CTRL_ADDR, 32'h0);
		hold_until(2, 0);
		wr(alias_at(rnd), {rnd[31:8], b[0]});
		hold_until(2, 0);
		wr(alias_at(rnd), {24'h0, b[1]});
		wr(alias_at(rnd), {24'h0, b[2]});
		hold_until(1, 2);
		check({24'h0, usrtbp_line_i.got.pop_front()}, {24'h0, b[0]});
		check({24'h0, usrtbp_line_i.got.pop_front()}, {24'h0, b[2]});
		wr(`USRTBP_CTRL_ADDR, 32'h1);
		// Two more than the depth while the shifter is busy: the extra writes meet a full FIFO
		for (int i = 0; i < `USRTBP_FIFO_DEPTH + 2; i++) begin
			rnd = lfsr(rnd);
			if (i < 2) b[i] = rnd[7:0];
			wr(alias_at(rnd), rnd);
		end
		rd(`USRTBP_STAT_ADDR, v);
		check(v, stat(0, 0, 0, 1));
		hold_until(1, 2);
		check({24'h0, usrtbp_line_i.got.pop_front()}, {24'h0, b[0]});
		check({24'h0, usrtbp_line_i.got.pop_front()}, {24'h0, b[1]});
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		wr(`USRTBP_CTRL_ADDR, 32'h2);
		rd(`USRTBP_CTRL_ADDR, v);
		check(v, 32'h2);
		// Infrared output loops back to the infrared input
		rnd = lfsr(rnd);
		hold_until(2, 0);
		wr(alias_at(rnd), rnd);
		hold_until(0, 0);
		rd(alias_at(rnd), v);
		check(v, {24'h0, rnd[7:0]});
		wr(`USRTBP_CTRL_ADDR, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
